// *** logic/frame_builder_pkg.sv ***
// Purpose: constants shared by the response frame builder
// Assumes: bytes leave msb of each multi-byte field first
// Notes: register offsets are byte addresses on the axi4-lite bus
package frame_builder_pkg;
    localparam logic [7:0] DELIM = 8'h7e;
    localparam logic [7:0] LEN_HI = 8'h00;
    localparam logic [7:0] TYPE_CMD_RSP = 8'h88;
    localparam logic [7:0] TYPE_STATUS = 8'h8a;
    localparam logic [7:0] CK_BASE = 8'hff;
    localparam logic [7:0] ID_NONE = 8'h00;
    localparam logic [3:0] CMD_BASE_LEN = 4'h5;
    localparam logic [3:0] STAT_LEN = 4'h2;
    localparam logic [2:0] DATA_MAX = 3'h4;
    localparam int PAY_DEPTH = 9;
    // result codes
    localparam logic [7:0] RES_OK = 8'h00;
    localparam logic [7:0] RES_ERROR = 8'h01;
    localparam logic [7:0] RES_BAD_CMD = 8'h02;
    localparam logic [7:0] RES_BAD_PARAM = 8'h03;
    localparam logic [7:0] RES_TX_FAIL = 8'h04;
    // status codes
    localparam logic [7:0] ST_HW_RESET = 8'h00;
    localparam logic [7:0] ST_WDT_RESET = 8'h01;
    localparam logic [7:0] ST_JOINED = 8'h02;
    localparam logic [7:0] ST_DISASSOC = 8'h03;
    localparam logic [7:0] ST_COORD_UP = 8'h06;
    localparam logic [7:0] ST_KEY_UPDATED = 8'h07;
    localparam logic [7:0] ST_VOLT_LIMIT = 8'h0d;
    localparam logic [7:0] ST_KEY_EST = 8'h10;
    localparam logic [7:0] ST_STACK_ERR = 8'h80;
    // register map
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_STATE = 4'h4;
    localparam logic [3:0] A_IRQ_STAT = 4'h8;
    localparam logic [3:0] A_IRQ_MASK = 4'hc;
    localparam int IRQ_W = 4;
    localparam int B_CMD_DONE = 0;
    localparam int B_STAT_DONE = 1;
    localparam int B_SUPPRESS = 2;
    localparam int B_STACK_ERR = 3;
    localparam logic CTRL_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_HEAD = 4'b0010,
        S_PAY = 4'b0100,
        S_CK = 4'b1000
    } fb_state_t;
endpackage : frame_builder_pkg

// *** logic/api_response_frame_builder.sv ***
// Purpose: builds command response and status report frames onto a byte stream
// Assumes: upstream hands one record per response frame; uart drains tx bytes
// Notes: Behaviour
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module api_response_frame_builder
    import frame_builder_pkg::*;
(
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // axi4-lite slave
    input logic [3:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [3:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // command result records
    input logic cmd_valid,
    output logic cmd_ready,
    input logic [7:0] cmd_frame_id,
    input logic [7:0] cmd_name_hi,
    input logic [7:0] cmd_name_lo,
    input logic [7:0] cmd_result,
    input logic cmd_is_query,
    input logic [2:0] cmd_data_len,
    input logic [31:0] cmd_data,
    input logic cmd_last,
    // status events
    input logic stat_valid,
    output logic stat_ready,
    input logic [7:0] stat_code,
    input logic coord_formed,
    input logic boot_by_wdt,
    // byte stream to uart
    output logic tx_valid,
    input logic tx_ready,
    output logic [7:0] tx_data,
    // interrupt
    output logic irq
);
    fb_state_t st_q, st_d;
    logic [3:0] idx_q, idx_d, len_q, len_d;
    logic [7:0] sum_q, sum_d, tx_data_q, tx_data_d;
    logic [7:0] pay_q [PAY_DEPTH];
    logic [7:0] pay_d [PAY_DEPTH];
    logic is_cmd_q, is_cmd_d, boot_q, boot_d, coord_q, coord_d;
    logic [7:0] burst_q, burst_d;
    logic [IRQ_W-1:0] ev;
    logic hs, take_cmd, take_boot, take_coord, take_stat, idle_en;
    logic [31:0] shifted;
    logic [2:0] dlen;

    function automatic logic [7:0] cksum(input logic [7:0] s);
        cksum = CK_BASE - s;
    endfunction : cksum

    // register state
    logic en_q, en_d;
    logic [IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
    logic aw_h_q, aw_h_d, w_h_q, w_h_d, bv_q, bv_d, rv_q, rv_d;
    logic [3:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic ws_q, ws_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic do_wr;

    assign hs = tx_valid && tx_ready;
    assign idle_en = (st_q == S_IDLE) && en_q;
    // status reports take priority: they are rare and must not wait behind bursts
    assign take_boot = idle_en && boot_q;
    assign take_coord = idle_en && !boot_q && coord_q;
    assign stat_ready = idle_en && !boot_q && !coord_q;
    assign take_stat = stat_ready && stat_valid;
    assign cmd_ready = stat_ready && !stat_valid;
    assign take_cmd = cmd_ready && cmd_valid;
    assign dlen = (cmd_data_len > DATA_MAX) ? DATA_MAX : cmd_data_len;
    assign shifted = cmd_data << {(DATA_MAX - dlen), 3'b000};
    assign tx_valid = (st_q != S_IDLE);
    assign tx_data = tx_data_q;

    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        len_d = len_q;
        sum_d = sum_q;
        tx_data_d = tx_data_q;
        pay_d = pay_q;
        is_cmd_d = is_cmd_q;
        boot_d = boot_q && !take_boot;
        // a formed-network pulse during the take of an older one is kept
        coord_d = (coord_q && !take_coord) || coord_formed;
        burst_d = burst_q;
        ev = '0;
        if (take_boot || take_coord || take_stat) begin
            pay_d[0] = TYPE_STATUS;
            if (take_boot) begin
                pay_d[1] = boot_by_wdt ? ST_WDT_RESET : ST_HW_RESET;
            end else if (take_coord) begin
                pay_d[1] = ST_COORD_UP;
            end else begin
                // codes such as join, key or voltage events pass unchanged
                pay_d[1] = stat_code;
                ev[B_STACK_ERR] = (stat_code >= ST_STACK_ERR);
            end
            len_d = STAT_LEN;
            is_cmd_d = 1'b0;
        end
        if (take_cmd) begin
            burst_d = cmd_last ? 8'h00 : burst_q + 8'h01;
            if (cmd_frame_id == ID_NONE) begin
                ev[B_SUPPRESS] = 1'b1;
            end else begin
                pay_d[0] = TYPE_CMD_RSP;
                pay_d[1] = cmd_frame_id;
                pay_d[2] = cmd_name_hi;
                pay_d[3] = cmd_name_lo;
                pay_d[4] = cmd_result;
                for (int k = 0; k < DATA_MAX; k++) begin
                    pay_d[CMD_BASE_LEN + k] = shifted[31 - 8 * k -: 8];
                end
                len_d = cmd_is_query ? CMD_BASE_LEN + {1'b0, dlen} : CMD_BASE_LEN;
                is_cmd_d = 1'b1;
            end
        end
        if (take_boot || take_coord || take_stat
            || (take_cmd && cmd_frame_id != ID_NONE)) begin
            st_d = S_HEAD;
            idx_d = '0;
            sum_d = '0;
            tx_data_d = DELIM;
        end
        case (st_q)
            S_IDLE: begin
            end
            S_HEAD: begin
                if (hs) begin
                    if (idx_q == 4'h2) begin
                        st_d = S_PAY;
                        idx_d = '0;
                        tx_data_d = pay_q[0];
                    end else begin
                        idx_d = idx_q + 4'h1;
                        tx_data_d = (idx_q == 4'h0) ? LEN_HI : {4'h0, len_q};
                    end
                end
            end
            S_PAY: begin
                if (hs) begin
                    sum_d = sum_q + pay_q[idx_q];
                    if (idx_q == len_q - 4'h1) begin
                        st_d = S_CK;
                        tx_data_d = cksum(sum_q + pay_q[idx_q]);
                    end else begin
                        idx_d = idx_q + 4'h1;
                        tx_data_d = pay_q[idx_q + 4'h1];
                    end
                end
            end
            S_CK: begin
                if (hs) begin
                    st_d = S_IDLE;
                    ev[B_CMD_DONE] = is_cmd_q;
                    ev[B_STAT_DONE] = !is_cmd_q;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= S_IDLE;
            idx_q <= '0;
            len_q <= '0;
            sum_q <= '0;
            tx_data_q <= '0;
            is_cmd_q <= 1'b0;
            boot_q <= 1'b1; // report the reset once enabled
            coord_q <= 1'b0;
            burst_q <= '0;
            for (int i = 0; i < PAY_DEPTH; i++) begin
                pay_q[i] <= '0;
            end
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            len_q <= len_d;
            sum_q <= sum_d;
            tx_data_q <= tx_data_d;
            is_cmd_q <= is_cmd_d;
            boot_q <= boot_d;
            coord_q <= coord_d;
            burst_q <= burst_d;
            pay_q <= pay_d;
        end
    end

    // axi4-lite slave: address and data taken in either order
    assign s_axi_awready = !aw_h_q && !bv_q;
    assign s_axi_wready = !w_h_q && !bv_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign do_wr = aw_h_q && w_h_q;
    assign irq = |(ist_q & imask_q);

    always_comb begin
        aw_h_d = aw_h_q;
        w_h_d = w_h_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        en_d = en_q;
        imask_d = imask_q;
        ist_d = ist_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_h_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_h_d = 1'b1;
            wd_d = s_axi_wdata;
            ws_d = s_axi_wstrb[0];
        end
        if (do_wr) begin
            aw_h_d = 1'b0;
            w_h_d = 1'b0;
            bv_d = 1'b1;
            br_d = RESP_OKAY;
            case (awa_q)
                A_CTRL: if (ws_q) en_d = wd_q[0];
                A_IRQ_STAT: if (ws_q) ist_d = ist_q & ~wd_q[IRQ_W-1:0];
                A_IRQ_MASK: if (ws_q) imask_d = wd_q[IRQ_W-1:0];
                A_STATE: begin
                end
                default: br_d = RESP_SLVERR;
            endcase
        end else if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
        // new events win over a clear in the same cycle
        ist_d = ist_d | ev;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            case (s_axi_araddr)
                A_CTRL: rd_d = {31'h0, en_q};
                A_STATE: rd_d = {16'h0, burst_q, 3'h0, boot_q, st_q};
                A_IRQ_STAT: rd_d = {28'h0, ist_q};
                A_IRQ_MASK: rd_d = {28'h0, imask_q};
                default: begin
                    rd_d = '0;
                    rr_d = RESP_SLVERR;
                end
            endcase
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_h_q <= 1'b0;
            w_h_q <= 1'b0;
            awa_q <= '0;
            wd_q <= '0;
            ws_q <= 1'b0;
            bv_q <= 1'b0;
            br_q <= RESP_OKAY;
            rv_q <= 1'b0;
            rd_q <= '0;
            rr_q <= RESP_OKAY;
            en_q <= CTRL_RST;
            ist_q <= '0;
            imask_q <= '0;
        end else begin
            aw_h_q <= aw_h_d;
            w_h_q <= w_h_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            en_q <= en_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_delim; st_q == S_HEAD && idx_q == 4'h0 |-> tx_data == DELIM; endproperty
    a_delim: assert property (p_delim) else $error("bad delimiter");
    property p_type_cmd;
        st_q == S_PAY && idx_q == 4'h0 && is_cmd_q |-> tx_data == TYPE_CMD_RSP;
    endproperty
    a_type_cmd: assert property (p_type_cmd) else $error("bad response type");
    property p_type_stat;
        st_q == S_PAY && idx_q == 4'h0 && !is_cmd_q |-> tx_data == TYPE_STATUS;
    endproperty
    a_type_stat: assert property (p_type_stat) else $error("bad status type");
    property p_ck; st_q == S_CK |-> tx_data == CK_BASE - sum_q; endproperty
    a_ck: assert property (p_ck) else $error("bad checksum");
    property p_suppress;
        take_cmd && cmd_frame_id == ID_NONE |=> st_q == S_IDLE && ist_q[B_SUPPRESS];
    endproperty
    a_suppress: assert property (p_suppress) else $error("frame not suppressed");
    property p_echo;
        take_cmd && cmd_frame_id != ID_NONE |=> pay_q[1] == $past(cmd_frame_id);
    endproperty
    a_echo: assert property (p_echo) else $error("frame id not echoed");
    property p_name;
        take_cmd && cmd_frame_id != ID_NONE
        |=> pay_q[2] == $past(cmd_name_hi) && pay_q[3] == $past(cmd_name_lo);
    endproperty
    a_name: assert property (p_name) else $error("command name wrong");
    property p_res;
        take_cmd && cmd_frame_id != ID_NONE |=> pay_q[4] == $past(cmd_result);
    endproperty
    a_res: assert property (p_res) else $error("result wrong");
    property p_wr_len;
        take_cmd && cmd_frame_id != ID_NONE && !cmd_is_query |=> len_q == CMD_BASE_LEN;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write carried data");
    property p_coord; take_coord |=> pay_q[1] == ST_COORD_UP ##1 st_q == S_HEAD; endproperty
    a_coord: assert property (p_coord) else $error("coordinator code wrong");
    property p_boot;
        take_boot |=> pay_q[1] == ($past(boot_by_wdt) ? ST_WDT_RESET : ST_HW_RESET);
    endproperty
    a_boot: assert property (p_boot) else $error("reset code wrong");
    property p_stack; take_stat && stat_code >= ST_STACK_ERR |=> ist_q[B_STACK_ERR]; endproperty
    a_stack: assert property (p_stack) else $error("stack error not flagged");

    property p_cv_cmd; st_q == S_CK && hs && is_cmd_q; endproperty
    c_cmd: cover property (p_cv_cmd);
    property p_cv_stat; st_q == S_CK && hs && !is_cmd_q; endproperty
    c_stat: cover property (p_cv_stat);
    property p_cv_burst; take_cmd && !cmd_last ##[1:200] take_cmd && cmd_last; endproperty
    c_burst: cover property (p_cv_burst);
endmodule : api_response_frame_builder

// *** verif/host_rx_model.sv ***
// Purpose: host side of the uart byte stream, parses and counts frames
// Assumes: bytes move on tx_valid and tx_ready both high at a rising edge
// Notes: counters survive reset so the bench can total every frame
`timescale 1ns/1ps
module host_rx_model (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // byte stream
    input logic tx_valid,
    input logic [7:0] tx_data,
    output logic tx_ready,
    // tallies
    output int frames,
    output int errs
);
    int idx = 0;
    int len = 0;
    int seen = 0;
    int bad = 0;
    logic [7:0] sum = 8'h00;
    logic ready_q = 1'b0;
    assign tx_ready = ready_q;
    assign frames = seen;
    assign errs = bad;
    always @(posedge aclk) begin
        // random stalls, so the sender must hold each byte
        ready_q <= ($urandom % 4) != 0;
        if (!aresetn) begin
            idx = 0;
        end else if (tx_valid && tx_ready) begin
            if (idx == 0 && tx_data != 8'h7e) bad++;
            if (idx == 1) len = 256 * int'(tx_data);
            if (idx == 2) len = len + int'(tx_data);
            if (idx == 3) sum = 8'h00;
            // any status value is taken, unknown ones too
            if (idx >= 3 && idx < len + 3) sum = sum + tx_data;
            if (idx == len + 3 && idx > 2) begin
                if (8'(sum + tx_data) != 8'hff) bad++;
                seen++;
                idx = 0;
            end else begin
                idx++;
            end
        end
    end
endmodule : host_rx_model

// *** verif/api_response_frame_builder_tb.sv ***
// Purpose: self-checking bench for the response frame builder
// Assumes: expected bytes are queued before the record that causes them
// Notes: a monitor pops the byte queue at every tx handshake
`timescale 1ns/1ps
module api_response_frame_builder_tb;
    import frame_builder_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cmd_data = 32'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic cmd_valid = 0, cmd_is_query = 0, cmd_last = 0, cmd_ready;
    logic [7:0] cmd_frame_id = 8'h0, cmd_name_hi = 8'h0, cmd_name_lo = 8'h0;
    logic [7:0] cmd_result = 8'h0, stat_code = 8'h0, tx_data;
    logic [2:0] cmd_data_len = 3'h0;
    logic stat_valid = 0, stat_ready, coord_formed = 0, boot_by_wdt = 0;
    logic tx_valid, tx_ready, irq;
    int frames, errs, bad_count = 0, samples_checked = 0, nfr = 0;
    logic [7:0] eq[$], pl[$];
    logic [31:0] rq[$];
    logic [1:0] bq[$];
    logic [7:0] codes[10] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0d, 8'h10,
        8'h80, 8'h9c, 8'h55};
    always #2.5 aclk = ~aclk;
    api_response_frame_builder DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_frame_id(cmd_frame_id),
        .cmd_name_hi(cmd_name_hi), .cmd_name_lo(cmd_name_lo), .cmd_result(cmd_result),
        .cmd_is_query(cmd_is_query), .cmd_data_len(cmd_data_len), .cmd_data(cmd_data),
        .cmd_last(cmd_last),
        .stat_valid(stat_valid), .stat_ready(stat_ready), .stat_code(stat_code),
        .coord_formed(coord_formed), .boot_by_wdt(boot_by_wdt),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .irq(irq));
    host_rx_model host (.aclk(aclk), .aresetn(aresetn), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .frames(frames), .errs(errs));
    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic lim(inout int n);
        n++;
        if (n > 500) begin
            bad_count++;
            conclude();
        end
    endtask : lim
    // wraps pl into a complete frame on the expected byte queue
    task automatic frame();
        logic [7:0] s;
        s = 8'h00;
        eq.push_back(8'h7e);
        eq.push_back(8'h00);
        eq.push_back(8'(pl.size()));
        foreach (pl[i]) begin
            eq.push_back(pl[i]);
            s = s + pl[i];
        end
        eq.push_back(8'hff - s);
        nfr++;
        pl.delete();
    endtask : frame
    always @(posedge aclk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (eq.size() > 0) begin
                chk(32'(tx_data), 32'(eq.pop_front()));
            end else begin
                chk(32'(tx_data), 32'hffff_ffff);
            end
        end
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            chk(s_axi_rdata, rq.pop_front());
            chk(32'(s_axi_rresp), rq.pop_front());
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            chk(32'(s_axi_bresp), 32'(bq.pop_front()));
        end
    end
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        logic aw, w;
        aw = 0;
        w = 0;
        n = 0;
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            lim(n);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 0;
            end
        end while (!(aw && w));
        while (s_axi_bvalid !== 1'b1) begin
            @(posedge aclk);
            lim(n);
        end
        s_axi_bready <= 0;
    endtask : axw
    task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        rq.push_back(d);
        rq.push_back(32'(r));
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            lim(n);
        end while (!s_axi_arready);
        s_axi_arvalid <= 0;
        while (s_axi_rvalid !== 1'b1) begin
            @(posedge aclk);
            lim(n);
        end
        s_axi_rready <= 0;
    endtask : axr
    task automatic cmd(input logic [7:0] id, input logic [7:0] hi, input logic [7:0] lo,
        input logic [7:0] res, input logic q, input logic [2:0] dl, input logic last);
        int n;
        logic [31:0] d;
        n = 0;
        d = $urandom;
        pl = '{8'h88, id, hi, lo, res};
        if (q) for (int i = (dl > 3'h4) ? 3 : int'(dl) - 1; i >= 0; i--) pl.push_back(d[8*i +: 8]);
        if (id != 8'h00) frame();
        else pl.delete();
        @(posedge aclk);
        {cmd_frame_id, cmd_name_hi, cmd_name_lo, cmd_result} <= {id, hi, lo, res};
        {cmd_is_query, cmd_data_len, cmd_data, cmd_last} <= {q, dl, d, last};
        cmd_valid <= 1;
        do begin
            @(posedge aclk);
            lim(n);
        end while (!cmd_ready);
        cmd_valid <= 0;
    endtask : cmd
    task automatic stat(input logic [7:0] c);
        int n;
        n = 0;
        pl = '{8'h8a, c};
        frame();
        @(posedge aclk);
        stat_code <= c;
        stat_valid <= 1;
        do begin
            @(posedge aclk);
            lim(n);
        end while (!stat_ready);
        stat_valid <= 0;
    endtask : stat
    task automatic drain();
        int n;
        n = 0;
        while (eq.size() > 0) begin
            @(posedge aclk);
            lim(n);
        end
        repeat (3) @(posedge aclk);
    endtask : drain
    task automatic rst(input logic wdt);
        @(posedge aclk);
        aresetn <= 0;
        boot_by_wdt <= wdt;
        repeat (20) @(posedge aclk);
        pl = '{8'h8a, {7'h0, wdt}};
        frame();
        aresetn <= 1;
    endtask : rst
    initial begin
        void'($urandom(40));
        rst(0);
        drain();
        axr(A_CTRL, 32'h1, RESP_OKAY);
        axr(4'h2, 32'h0, RESP_SLVERR);
        axw(4'h2, 32'h0, RESP_SLVERR);
        axr(A_IRQ_STAT, 32'h2, RESP_OKAY);
        axr(A_STATE, 32'h1, RESP_OKAY);
        axw(A_IRQ_MASK, 32'hf, RESP_OKAY);
        axr(A_IRQ_MASK, 32'hf, RESP_OKAY);
        chk(32'(irq), 32'h1);
        axw(A_IRQ_STAT, 32'hf, RESP_OKAY);
        chk(32'(irq), 32'h0);
        axw(A_CTRL, 32'h0, RESP_OKAY);
        chk(32'(cmd_ready), 32'h0);
        axw(A_CTRL, 32'h1, RESP_OKAY);
        for (int r = 0; r < 5; r++) cmd(8'($urandom_range(1, 255)), 8'h42, 8'h44, 8'(r), 0,
            3'($urandom), 1);
        for (int i = 0; i < 6; i++) cmd(8'($urandom_range(1, 255)), 8'h42, 8'h44, 8'h00, 1,
            (i == 5) ? 3'h7 : 3'(i), 1);
        for (int i = 0; i < 2; i++) cmd(8'h5a, 8'h4e, 8'h44, 8'h00, 1, 3'h2, 0);
        drain();
        axr(A_STATE, 32'h0000_0201, RESP_OKAY);
        cmd(8'h5a, 8'h4e, 8'h44, 8'h00, 1, 3'h2, 1);
        cmd(8'h00, 8'h42, 8'h44, 8'h00, 0, 3'h0, 1);
        foreach (codes[i]) stat(codes[i]);
        pl = '{8'h8a, 8'h06};
        frame();
        @(posedge aclk);
        coord_formed <= 1;
        @(posedge aclk);
        coord_formed <= 0;
        drain();
        axr(A_IRQ_STAT, 32'hf, RESP_OKAY);
        chk(32'(irq), 32'h1);
        rst(1);
        drain();
        axr(A_IRQ_STAT, 32'h2, RESP_OKAY);
        chk(32'(frames), 32'(nfr));
        chk(32'(errs), 32'h0);
        conclude();
    end
endmodule : api_response_frame_builder_tb
